// ==== verilog/adc_serial_frame.sv ====
// Purpose: Device side of the serial frame and daisy chain link
// Assumes: All pins are asynchronous and pass two flip-flops
// Notes:   Results come from the converter through word_fifo
`include "adc_link_cfg.svh"
`timescale 1ns/10ps
module adc_serial_frame (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire adc_link_pkg::pin_in_t   pin_i,
  input  wire logic [`WORD_W-1:0]      res_data,
  input  wire logic                    res_valid,
  output logic                         res_ready,
  output logic                         sdo,
  output logic                         sdo_oe_n,
  output logic                         conv_start,
  output logic [`WORD_W-1:0]           cmd_word,
  output logic                         cmd_apply,
  output logic                         reg_defaults,
  output logic                         full_sleep_mode,
  output logic                         invalid_state
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0]            sync1_ff;
  logic [4:0]            sync2_ff;
  adc_link_pkg::pin_in_t pin_s;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          sync1_ff[gi] <= 1'b1;
          sync2_ff[gi] <= 1'b1;
        end else begin
          sync1_ff[gi] <= pin_i[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  assign pin_s = adc_link_pkg::pin_in_t'(sync2_ff);

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic sclk_d_ff;
  logic cs_n_d_ff;
  logic rp_low_d_ff;
  wire  sclk_fall = sclk_d_ff & ~pin_s.sclk;
  wire  cs_fall   = cs_n_d_ff & ~pin_s.cs_n;
  wire  cs_rise   = ~cs_n_d_ff & pin_s.cs_n;
  wire  rp_low    = ~pin_s.rsp_n;
  wire  rp_rel    = rp_low_d_ff & ~rp_low;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclk_d_ff   <= 1'b1;
      cs_n_d_ff   <= 1'b1;
      rp_low_d_ff <= 1'b0;
    end else begin
      sclk_d_ff   <= pin_s.sclk;
      cs_n_d_ff   <= pin_s.cs_n;
      rp_low_d_ff <= rp_low;
    end
  end

  // ----------------------------------------------------------------
  // Reset and sleep pin width decode
  // ----------------------------------------------------------------
  logic [5:0] low_cnt_ff;
  logic       sleep_ff;
  logic       defaults_ff;
  wire        low_sat     = (low_cnt_ff == `LOW_CNT_MAX);
  wire        sleep_enter = rp_low & (low_cnt_ff == `SLEEP_CYC - 6'h01);
  wire        rst_pulse   = rp_rel & (low_cnt_ff > `RST_MIN_CYC);
  wire        nxt_sleep   = sleep_enter | (sleep_ff & ~rp_rel);
  wire        nxt_defaults = rst_pulse | sleep_enter;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_cnt_ff  <= 6'h00;
      sleep_ff    <= 1'b0;
      defaults_ff <= 1'b0;
    end else begin
      low_cnt_ff  <= rp_low ? (low_cnt_ff + {5'h00, ~low_sat}) : 6'h00;
      sleep_ff    <= nxt_sleep;
      defaults_ff <= nxt_defaults;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  logic [`WORD_W-1:0] fifo_data;
  logic               fifo_valid;
  logic               fifo_pop;

  word_fifo #(
    .W (`WORD_W),
    .D (`FIFO_D)
  ) u_word_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   (res_data),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  adc_link_pkg::frame_st_t st_ff;
  adc_link_pkg::frame_st_t nxt_st;
  logic [3:0]              cnt_ff;
  wire                     in_cmd   = (st_ff == adc_link_pkg::ST_CMD);
  wire                     in_data  = (st_ff == adc_link_pkg::ST_DATA);
  wire                     in_idle  = (st_ff == adc_link_pkg::ST_IDLE);
  wire                     fall_cmd = in_cmd & sclk_fall;
  wire                     fall_16  = fall_cmd & (cnt_ff == `CMD_LAST);
  wire                     fall_dat = in_data & sclk_fall;
  wire                     start    = in_idle & cs_fall & ~sleep_ff;
  wire                     abort    = in_cmd & cs_rise;

  assign fifo_pop = fall_16;

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      adc_link_pkg::ST_IDLE: begin
        if (start) begin
          nxt_st = adc_link_pkg::ST_CMD;
        end
      end
      adc_link_pkg::ST_CMD: begin
        if (cs_rise) begin
          nxt_st = adc_link_pkg::ST_IDLE;
        end else if (fall_16) begin
          nxt_st = adc_link_pkg::ST_DATA;
        end
      end
      adc_link_pkg::ST_DATA: begin
        if (cs_rise) begin
          nxt_st = adc_link_pkg::ST_IDLE;
        end
      end
      adc_link_pkg::ST_SLEEP: begin
        if (~sleep_ff) begin
          nxt_st = adc_link_pkg::ST_IDLE;
        end
      end
      default: nxt_st = adc_link_pkg::ST_IDLE;
    endcase
    if (sleep_ff) begin
      nxt_st = adc_link_pkg::ST_SLEEP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff  <= adc_link_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= start ? 4'h0 : (cnt_ff + {3'h0, fall_cmd & ~fall_16});
    end
  end

  // ----------------------------------------------------------------
  // Command capture and apply
  // ----------------------------------------------------------------
  logic [`WORD_W-1:0] cmd_sh_ff;
  logic [`WORD_W-1:0] cmd_pend_ff;
  logic               pend_vld_ff;
  logic [`WORD_W-1:0] cmd_word_ff;
  logic               cmd_apply_ff;
  logic               conv_start_ff;
  logic               invalid_ff;
  wire  [`WORD_W-1:0] cmd_full = {cmd_sh_ff[`WORD_W-2:0], pin_s.sdi};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_sh_ff     <= `CMD_RESET;
      cmd_pend_ff   <= `CMD_RESET;
      pend_vld_ff   <= 1'b0;
      cmd_word_ff   <= `CMD_RESET;
      cmd_apply_ff  <= 1'b0;
      conv_start_ff <= 1'b0;
      invalid_ff    <= 1'b0;
    end else begin
      if (fall_cmd) begin
        cmd_sh_ff <= cmd_full;
      end
      if (fall_16) begin
        cmd_pend_ff <= cmd_full;
        pend_vld_ff <= 1'b1;
      end else if (defaults_ff | start) begin
        pend_vld_ff <= 1'b0;
      end
      if (start & pend_vld_ff) begin
        cmd_word_ff <= cmd_pend_ff;
      end
      cmd_apply_ff  <= start & pend_vld_ff;
      conv_start_ff <= start;
      if (abort) begin
        invalid_ff <= 1'b1;
      end else if (fall_16) begin
        invalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output shift register and chain
  // ----------------------------------------------------------------
  logic [`WORD_W-1:0] sh_ff;
  logic               sdo_oe_n_ff;
  wire                res_ok  = fifo_valid & ~invalid_ff;
  wire  [`WORD_W-1:0] ld_word = res_ok ? fifo_data : `INVALID_WORD;
  wire                drive   = (nxt_st == adc_link_pkg::ST_CMD) |
                                (nxt_st == adc_link_pkg::ST_DATA);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sh_ff       <= `CMD_RESET;
      sdo_oe_n_ff <= 1'b1;
    end else begin
      sdo_oe_n_ff <= ~drive;
      if (start) begin
        sh_ff <= `CMD_RESET;
      end else if (fall_16) begin
        sh_ff <= ld_word;
      end else if (fall_dat) begin
        sh_ff <= {sh_ff[`WORD_W-2:0], pin_s.daisy};
      end
    end
  end

  // ----------------------------------------------------------------
  // Output assignments
  // ----------------------------------------------------------------
  assign sdo             = sh_ff[`WORD_W-1];
  assign sdo_oe_n        = sdo_oe_n_ff;
  assign conv_start      = conv_start_ff;
  assign cmd_word        = cmd_word_ff;
  assign cmd_apply       = cmd_apply_ff;
  assign reg_defaults    = defaults_ff;
  assign full_sleep_mode = sleep_ff;
  assign invalid_state   = invalid_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_sdo_low_cmd: assert property (
    @(posedge sys_clk) disable iff (rst)
    (in_cmd & ~sdo_oe_n_ff) |-> (sdo == 1'b0)
  ) else $error("serial output not low in command field");

  chk_sdo_off_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    (~in_idle & cs_rise) |=> sdo_oe_n_ff ##1 (sdo_oe_n_ff | conv_start_ff)
  ) else $error("serial output still driven after select rose");

  chk_cmd_bit_take: assert property (
    @(posedge sys_clk) disable iff (rst)
    (fall_cmd & ~fall_16) |=> (cmd_sh_ff[0] == $past(pin_s.sdi))
  ) else $error("command bit not taken on clock fall");

  chk_cmd_last_bit: assert property (
    @(posedge sys_clk) disable iff (rst | defaults_ff)
    fall_16 |=> (cmd_pend_ff == $past(cmd_full)) && pend_vld_ff && in_data
  ) else $error("sixteenth fall did not complete the command");

  chk_apply_at_start: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(cmd_apply_ff) |-> conv_start_ff && (cmd_word_ff == $past(cmd_pend_ff))
  ) else $error("command applied away from a frame start");

  chk_conv_on_fall: assert property (
    @(posedge sys_clk) disable iff (rst)
    start |=> conv_start_ff ##1 !conv_start_ff
  ) else $error("conversion start not a single pulse at select fall");

  chk_msb_present: assert property (
    @(posedge sys_clk) disable iff (rst)
    fall_16 |=> (sdo == $past(ld_word[`WORD_W-1])) && !sdo_oe_n_ff
  ) else $error("result msb not shown on sixteenth fall");

  chk_chain_shift: assert property (
    @(posedge sys_clk) disable iff (rst)
    fall_dat |=> (sh_ff == {$past(sh_ff[`WORD_W-2:0]), $past(pin_s.daisy)})
  ) else $error("chain bit not shifted through");

  chk_sleep_entry: assert property (
    @(posedge sys_clk) disable iff (rst)
    sleep_enter |=> full_sleep_mode && reg_defaults ##1 (st_ff == adc_link_pkg::ST_SLEEP)
  ) else $error("long low pulse did not enter full sleep");

  chk_short_reset: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rp_rel & (low_cnt_ff > `RST_MIN_CYC) & (low_cnt_ff <= `RST_MAX_CYC))
      |=> reg_defaults && !full_sleep_mode
  ) else $error("short low pulse did not restore defaults");

  chk_abort_invalid: assert property (
    @(posedge sys_clk) disable iff (rst)
    abort |=> invalid_ff && in_idle
  ) else $error("early select rise did not mark data invalid");

  chk_sleep_ignore: assert property (
    @(posedge sys_clk) disable iff (rst)
    (sleep_ff & $past(sleep_ff)) |-> !conv_start_ff && sdo_oe_n_ff
  ) else $error("frame activity while in full sleep");

  chk_result_load: assert property (
    @(posedge sys_clk) disable iff (rst)
    (fall_16 & fifo_valid & ~invalid_ff) |=> (sh_ff == $past(fifo_data))
  ) else $error("result word not loaded into shift register");

  chk_invalid_word: assert property (
    @(posedge sys_clk) disable iff (rst)
    (fall_16 & (invalid_ff | ~fifo_valid)) |=> (sh_ff == `INVALID_WORD)
  ) else $error("invalid frame did not load the invalid word");

  chk_oe_in_frame: assert property (
    @(posedge sys_clk) disable iff (rst)
    (in_cmd | in_data) |-> !sdo_oe_n_ff
  ) else $error("serial output released inside a frame");

  chk_sleep_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    (sleep_ff & rp_low) |=> sleep_ff
  ) else $error("full sleep left while reset pin still low");

  chk_cmd_word_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !cmd_apply_ff |-> $stable(cmd_word_ff)
  ) else $error("applied command changed away from a frame start");

endmodule

// ==== verilog/adc_link_cfg.svh ====
// Purpose: Constants of the serial frame interface
// Assumes: sys_clk at 125 MHz
// Notes:   Timing counts derive from the ns figures
// Notes on behaviour
// - Reset pin low over 40 ns, at most 100 ns: defaults, no sleep.
// - Reset pin low 400 ns or more: full sleep and register defaults.
// - Reset pin acts at any time, whatever the other pins do.
// - In full sleep all digital inputs but the reset pin are ignored.
// - Select falling starts frame and a conversion of the channel chosen before.
// - Command bits are taken on serial clock falls one to sixteen.
// - Serial output stays low for the first sixteen clock cycles.
// - Sixteenth fall takes the last command bit; later bits are ignored.
// - Sixteenth fall shows result msb; lsb is out by the 32nd fall.
// - Once result bits are out, chain input bits follow until the next conversion.
// - Select rising turns the serial output off until the next frame.
// - Chain operation needs no setting; it follows from wiring only.
// - Finished conversion loads the result into a 16-bit shift register; here it queues in word_fifo and loads at the sixteenth fall.
// - Every fall after the sixteenth shifts chain input in and next bit out.
// - Command received in a frame is applied at the next select falling.
// - Select rising before a full command makes data invalid until one arrives.
`ifndef ADC_LINK_CFG_SVH
`define ADC_LINK_CFG_SVH
`define CLK_NS        8
`define RST_MIN_NS    40
`define RST_MAX_NS    100
`define SLEEP_NS      400
`define RST_MIN_CYC   6'((`RST_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_MAX_CYC   6'(`RST_MAX_NS / `CLK_NS)
`define SLEEP_CYC     6'((`SLEEP_NS + `CLK_NS - 1) / `CLK_NS)
`define LOW_CNT_MAX   6'h3F
`define CMD_LAST      4'hF
`define WORD_W        16
`define FIFO_D        16
`define INVALID_WORD  16'hFFFF
`define CMD_RESET     16'h0000
`endif

// ==== verilog/adc_link_pkg.sv ====
// Purpose: Types of the serial frame interface
// Assumes: Constants come from adc_link_cfg.svh
// Notes:   Pin struct order matches the synchroniser bits
package adc_link_pkg;

  typedef struct packed {
    logic rsp_n;
    logic daisy;
    logic sdi;
    logic sclk;
    logic cs_n;
  } pin_in_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CMD   = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_SLEEP = 4'b1000
  } frame_st_t;

endpackage

// ==== verilog/word_fifo.sv ====
// Purpose: Result buffer between converter and shift register
// Assumes: Single clock, synchronous reset
// Notes:   Flags are registered
`timescale 1ns/10ps
module word_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   count_ff;
  logic          room_ff;
  logic          empty_ff;
  logic [AW:0]   nxt_count;
  wire           push = in_valid & room_ff;
  wire           pop  = out_ready & ~empty_ff;

  assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready  = room_ff;
  assign out_valid = ~empty_ff;
  assign out_data  = mem[rd_ptr_ff];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      room_ff   <= 1'b1;
      empty_ff  <= 1'b1;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop);
      count_ff  <= nxt_count;
      room_ff   <= (nxt_count != (AW+1)'(D));
      empty_ff  <= (nxt_count == '0);
    end
  end
endmodule

// ==== testbench/host_model.sv ====
// Purpose: Host controller on the far side of the serial frame link
// Assumes: Link clock of 160 ns made here, idle high between frames
// Notes:   Tasks are called by the bench; sdo line is inverted while released
`timescale 1ns/10ps
module host_model (
  output adc_link_pkg::pin_in_t pins,
  input  wire logic             sdo,
  input  wire logic             sdo_oe_n
);
  // ----------------------------------------
  // Pins
  // ----------------------------------------
  logic line;

  // Released line shows the inverse of the last value
  assign line = sdo_oe_n ? ~sdo : sdo;

  initial begin
    pins = 5'h13;
  end

  // ----------------------------------------
  // Frame: one select, nfall serial clock falls, one device selected
  // ----------------------------------------
  task automatic frame(input logic [15:0] cmd, input int nfall,
                       input logic [15:0] chain, output logic [47:0] got);
    int k;
    got = '0;
    pins.cs_n = 1'b0;
    #80;
    for (k = 1; k <= nfall; k++) begin
      pins.sdi = (k <= 16) ? cmd[16-k] : ~pins.sdi;
      pins.daisy = (k >= 17 && k <= 32) ? chain[32-k] : 1'b0;
      #80;
      if (k > 1) got = {got[46:0], line};
      pins.sclk = 1'b0;
      #80;
      pins.sclk = 1'b1;
    end
    #80;
    pins.cs_n = 1'b1;
    #80;
  endtask

  // Short low pulse on the reset pin, kept out of the 100 to 400 ns band
  task automatic pulse(input int ns);
    pins.rsp_n = 1'b0;
    #(ns);
    pins.rsp_n = 1'b1;
    #200;
  endtask

  task automatic hold_rst(input logic lvl);
    pins.rsp_n = lvl;
  endtask
endmodule

// ==== testbench/adc_serial_frame_tb.sv ====
// Purpose: Self-checking bench of the serial frame device side
// Assumes: Host model drives the pins, bench feeds results
// Notes:   Pin changes and checks stay off the clock edges
`timescale 1ns/10ps
module adc_serial_frame_tb;
  `define CHK(nm, exp, act) begin checked++; if ((act) !== (exp)) begin num_errors++; \
    $display("unexpected %s exp %0h got %0h", nm, exp, act); end end

  logic                   sys_clk;
  logic                   rst;
  adc_link_pkg::pin_in_t  pin_i;
  logic [15:0]            res_data;
  logic                   res_valid;
  logic                   res_ready;
  logic                   sdo;
  logic                   sdo_oe_n;
  logic                   conv_start;
  logic [15:0]            cmd_word;
  logic                   cmd_apply;
  logic                   reg_defaults;
  logic                   full_sleep_mode;
  logic                   invalid_state;
  logic [15:0]            last_cmd = '0;
  logic [47:0]            got;
  logic [47:0]            exp_w;
  int                     num_errors = 0;
  int                     checked = 0;
  int                     n_conv = 0;
  int                     n_dflt = 0;
  int                     cyc = 0;

  adc_serial_frame u_adc_serial_frame (
    .sys_clk(sys_clk), .rst(rst), .pin_i(pin_i), .res_data(res_data),
    .res_valid(res_valid), .res_ready(res_ready), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .conv_start(conv_start), .cmd_word(cmd_word), .cmd_apply(cmd_apply),
    .reg_defaults(reg_defaults), .full_sleep_mode(full_sleep_mode),
    .invalid_state(invalid_state)
  );

  host_model u_host_model (.pins(pin_i), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Monitor and timeout
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (conv_start === 1'b1) n_conv++;
    if (reg_defaults === 1'b1) n_dflt++;
    if (cmd_apply === 1'b1) last_cmd = cmd_word;
    if (cyc == 40000) begin
      num_errors++;
      close_out;
    end
  end

  task close_out;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task push(input logic [15:0] w);
    @(posedge sys_clk);
    #1 res_data = w;
    res_valid = 1'b1;
    do @(posedge sys_clk); while (res_ready !== 1'b1);
    #1 res_valid = 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_chain;
    push(16'hC3A5);
    n_conv = 0;
    u_host_model.frame(16'h1234, 48, 16'h9E61, got);
    `CHK("chain", {16'h0000, 16'hC3A5, 16'h9E61}, got)
    `CHK("conv", 1, n_conv)
    `CHK("cmd held", 16'h0000, cmd_word)
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("oe", 1'b1, sdo_oe_n)
    $display("done chain");
  endtask

  task t_cmd;
    u_host_model.frame(16'h5AF0, 32, 16'h0000, got);
    `CHK("cmd 1", 16'h1234, last_cmd)
    `CHK("empty", 48'h0000_0000_FFFF, got)
    u_host_model.frame(16'h0000, 16, 16'h0000, got);
    `CHK("cmd 2", 16'h5AF0, last_cmd)
    $display("done cmd");
  endtask

  task t_fifo;
    int n;
    int i;
    n = 0;
    @(posedge sys_clk);
    #1 res_data = 16'h0000;
    res_valid = 1'b1;
    repeat (24) begin
      @(posedge sys_clk);
      if (res_ready === 1'b1) n++;
      #1 res_data = {4{4'(n)}};
    end
    res_valid = 1'b0;
    `CHK("depth", 16, n)
    for (i = 0; i < 17; i++) begin
      exp_w = (i < 16) ? {32'h0, {4{4'(i)}}} : 48'hFFFF;
      u_host_model.frame(16'h0000, 32, 16'h0000, got);
      `CHK("word", exp_w, got)
    end
    $display("done fifo");
  endtask

  task t_abort;
    u_host_model.frame(16'hFFFF, 8, 16'h0000, got);
    `CHK("invalid", 1'b1, invalid_state)
    push(16'h7E81);
    u_host_model.frame(16'h0000, 32, 16'h0000, got);
    `CHK("abort word", 48'h0000_0000_FFFF, got)
    `CHK("recovered", 1'b0, invalid_state)
    $display("done abort");
  endtask

  task t_pulse;
    int ns_tab[2] = '{32, 80};
    int i;
    for (i = 0; i < 2; i++) begin
      n_dflt = 0;
      u_host_model.pulse(ns_tab[i]);
      `CHK("defaults", i, n_dflt)
      `CHK("no sleep", 1'b0, full_sleep_mode)
    end
    $display("done pulse");
  endtask

  task t_sleep;
    n_dflt = 0;
    n_conv = 0;
    u_host_model.hold_rst(1'b0);
    #600;
    `CHK("sleep", 1'b1, full_sleep_mode)
    u_host_model.frame(16'h1234, 32, 16'h0000, got);
    `CHK("ignored", 0, n_conv)
    `CHK("sleep oe", 1'b1, sdo_oe_n)
    u_host_model.hold_rst(1'b1);
    #96;
    `CHK("awake", 1'b0, full_sleep_mode)
    `CHK("sleep defaults", 2, n_dflt)
    $display("done sleep");
  endtask

  initial begin
    rst = 1'b1;
    res_data = 16'h0000;
    res_valid = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    t_chain;
    t_cmd;
    t_fifo;
    t_abort;
    t_pulse;
    t_sleep;
    close_out;
  end
endmodule
